// ===== pkg/route_defs.vh
// constants for the front-panel routing editor
`ifndef ROUTE_DEFS_VH
`define ROUTE_DEFS_VH

// apb register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ROUTE 8'h04
`define OFS_STATUS 8'h08
`define OFS_PENDING 8'h0c
`define OFS_SERIAL 8'h10

// control register fields
`define CTRL_LOCK_BIT 0
`define CTRL_RESET 32'h0000_0000

// route word fields (audio out1, audio out2, video out1, video out2)
`define RT_A_LSB 0
`define RT_V_LSB 8
`define ROUTE_RESET 6'h00
`define ROUTE_MAX 3'h4

// status register fields
`define ST_LOCAL_BIT 0
`define ST_SPLIT_BIT 1
`define ST_DIFF_BIT 2
`define ST_LINE_ERR_BIT 3
`define ST_VIDEO_BIT 4
`define ST_SEL_LSB 8

// serial framing characters
`define CHAR_CR 8'h0d
`define CHAR_PRINT_LO 8'h20
`define CHAR_PRINT_HI 8'h7e

// indicator flash timing
`define CLK_MHZ 125
`define SLOW_HALF_MS 250
`define FAST_HALF_MS 50
`define SLOW_HALF_CYC (`SLOW_HALF_MS * 1000 * `CLK_MHZ)
`define FAST_HALF_CYC (`FAST_HALF_MS * 1000 * `CLK_MHZ)
`define REFUSE_HALVES 3'h6

`endif

// ===== hw/flash_divider.v
// blink rate generator for the panel indicators
`timescale 1ns/100ps
module flash_divider #(
  parameter [31:0] SLOW_HALF = 32'd31250000,
  parameter [31:0] FAST_HALF = 32'd6250000
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // blink phases
  output reg slow_phase_out,
  output reg fast_phase_out,
  output reg fast_tick_out
);

reg [31:0] slow_cnt_ff;
reg [31:0] fast_cnt_ff;

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_in or negedge rst_n_in) begin
  if (!rst_n_in) begin
    slow_cnt_ff <= 32'h0;
    fast_cnt_ff <= 32'h0;
    slow_phase_out <= 1'b0;
    fast_phase_out <= 1'b0;
    fast_tick_out <= 1'b0;
  end else begin
    fast_tick_out <= 1'b0;
    if (slow_cnt_ff >= SLOW_HALF - 32'h1) begin
      slow_cnt_ff <= 32'h0;
      slow_phase_out <= ~slow_phase_out;
    end else begin
      slow_cnt_ff <= slow_cnt_ff + 32'h1;
    end
    if (fast_cnt_ff >= FAST_HALF - 32'h1) begin
      fast_cnt_ff <= 32'h0;
      fast_phase_out <= ~fast_phase_out;
      fast_tick_out <= 1'b1;
    end else begin
      fast_cnt_ff <= fast_cnt_ff + 32'h1;
    end
  end
end

endmodule

// ===== hw/front_panel_route_editor.v
// front-panel route editor for a four-input, two-output switch
`timescale 1ns/100ps
`include "route_defs.vh"
module front_panel_route_editor #(
  parameter [31:0] SLOW_HALF_CYC = `SLOW_HALF_CYC,
  parameter [31:0] FAST_HALF_CYC = `FAST_HALF_CYC
) (
  // clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // front-panel buttons, one-cycle presses
  input wire [3:0] input_btn_in,
  input wire [1:0] output_btn_in,
  input wire split_btn_in,
  input wire audio_btn_in,
  input wire video_btn_in,
  input wire commit_btn_in,
  input wire local_btn_in,
  input wire system_btn_in,
  // front-panel indicators
  output reg local_led_out,
  output reg system_mode_indicator_out,
  output reg split_led_out,
  output reg audio_led_out,
  output reg video_led_out,
  output reg commit_led_out,
  output reg [3:0] input_led_out,
  output reg [1:0] output_led_out,
  // active crosspoint routes, 3 bits per output, 0 = no source
  output reg [5:0] audio_route_out,
  output reg [5:0] video_route_out,
  // serial receive framing
  input wire [7:0] rx_data_in,
  input wire rx_valid_in,
  output reg line_ok_out,
  output reg line_bad_out
);

////////////////////////////////////////////////////////////////////////////////
// helpers
function [2:0] route_at;
  input [5:0] tbl;
  input idx;
  begin
    route_at = idx ? tbl[5:3] : tbl[2:0];
  end
endfunction

function [5:0] route_set;
  input [5:0] tbl;
  input idx;
  input [2:0] val;
  begin
    route_set = idx ? {val, tbl[2:0]} : {tbl[5:3], val};
  end
endfunction

function printable;
  input [7:0] ch;
  begin
    printable = (ch >= `CHAR_PRINT_LO) && (ch <= `CHAR_PRINT_HI);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// reset release
reg [1:0] rst_sync_ff;
wire rst_n;

always @(posedge core_clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    rst_sync_ff <= 2'b00;
  end else begin
    rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
end
assign rst_n = rst_sync_ff[1];

////////////////////////////////////////////////////////////////////////////////
// blink phases
wire slow_phase;
wire fast_phase;
wire fast_tick;

flash_divider #(
  .SLOW_HALF(SLOW_HALF_CYC),
  .FAST_HALF(FAST_HALF_CYC)
) u_flash (
  .clk_in(core_clk_in),
  .rst_n_in(rst_n),
  .slow_phase_out(slow_phase),
  .fast_phase_out(fast_phase),
  .fast_tick_out(fast_tick)
);

////////////////////////////////////////////////////////////////////////////////
// state
reg local_ff;
reg lock_ff;
reg split_ff;
reg video_sel_ff;
reg [2:0] src_ff;
reg [5:0] pend_a_ff;
reg [5:0] pend_v_ff;
reg [2:0] refuse_ff;
reg line_err_ff;
reg line_bad_ff;
reg [7:0] line_cnt_ff;

wire apb_setup;
wire apb_write;
wire route_ok;
wire pend_diff;
wire edit_video;
wire out_idx;
wire [2:0] cur_dst;
wire [2:0] new_dst;
reg [2:0] btn_src;

assign apb_setup = psel_in & ~penable_in;
assign apb_write = psel_in & penable_in & pready_out & pwrite_in;
assign route_ok = (pwdata_in[2:0] <= `ROUTE_MAX) && (pwdata_in[5:3] <= `ROUTE_MAX) &&
                  (pwdata_in[10:8] <= `ROUTE_MAX) && (pwdata_in[13:11] <= `ROUTE_MAX);
assign pend_diff = (pend_a_ff != audio_route_out) || (pend_v_ff != video_route_out);
// in split mode edits go to the chosen portion, otherwise both move together
assign edit_video = split_ff ? video_sel_ff : 1'b1;
assign out_idx = ~output_btn_in[0];
assign cur_dst = route_at(edit_video ? pend_v_ff : pend_a_ff, out_idx);
assign new_dst = (cur_dst == src_ff) ? 3'h0 : src_ff;

always @* begin
  btn_src = 3'h0;
  if (input_btn_in[0]) begin
    btn_src = 3'h1;
  end else if (input_btn_in[1]) begin
    btn_src = 3'h2;
  end else if (input_btn_in[2]) begin
    btn_src = 3'h3;
  end else if (input_btn_in[3]) begin
    btn_src = 3'h4;
  end
end

////////////////////////////////////////////////////////////////////////////////
// mode, editing and routing
always @(posedge core_clk_in or negedge rst_n) begin
  if (!rst_n) begin
    local_ff <= 1'b0;
    lock_ff <= 1'b0;
    split_ff <= 1'b0;
    video_sel_ff <= 1'b1;
    src_ff <= 3'h0;
    pend_a_ff <= `ROUTE_RESET;
    pend_v_ff <= `ROUTE_RESET;
    audio_route_out <= `ROUTE_RESET;
    video_route_out <= `ROUTE_RESET;
    refuse_ff <= 3'h0;
  end else begin
    if (refuse_ff != 3'h0 && fast_tick) begin
      refuse_ff <= refuse_ff - 3'h1;
    end
    if (apb_write && paddr_in == `OFS_CTRL) begin
      lock_ff <= pwdata_in[`CTRL_LOCK_BIT];
    end
    if (apb_write && paddr_in == `OFS_CTRL && pwdata_in[`CTRL_LOCK_BIT]) begin
      local_ff <= 1'b0;
    end else if (!local_ff) begin
      if (apb_write && paddr_in == `OFS_ROUTE && route_ok) begin
        audio_route_out <= {pwdata_in[5:3], pwdata_in[2:0]};
        video_route_out <= {pwdata_in[13:11], pwdata_in[10:8]};
      end
      if (local_btn_in) begin
        if (lock_ff) begin
          refuse_ff <= `REFUSE_HALVES;
        end else begin
          local_ff <= 1'b1;
          src_ff <= 3'h0;
          video_sel_ff <= ~split_ff;
          pend_a_ff <= audio_route_out;
          pend_v_ff <= video_route_out;
        end
      end
    end else if (system_btn_in) begin
      local_ff <= 1'b0;
    end else if (commit_btn_in) begin
      audio_route_out <= pend_a_ff;
      video_route_out <= pend_v_ff;
    end else if (split_btn_in) begin
      if (split_ff) begin
        split_ff <= 1'b0;
        video_sel_ff <= 1'b1;
        pend_a_ff <= pend_v_ff;
      end else begin
        split_ff <= 1'b1;
        video_sel_ff <= 1'b0;
      end
    end else if (split_ff && video_btn_in) begin
      video_sel_ff <= 1'b1;
    end else if (split_ff && audio_btn_in) begin
      video_sel_ff <= 1'b0;
    end else if (btn_src != 3'h0) begin
      src_ff <= btn_src;
    end else if (output_btn_in != 2'b00 && src_ff != 3'h0) begin
      if (edit_video) begin
        pend_v_ff <= route_set(pend_v_ff, out_idx, new_dst);
      end
      if (!split_ff || !video_sel_ff) begin
        pend_a_ff <= route_set(pend_a_ff, out_idx, new_dst);
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// indicators
always @(posedge core_clk_in or negedge rst_n) begin
  if (!rst_n) begin
    local_led_out <= 1'b0;
    system_mode_indicator_out <= 1'b0;
    split_led_out <= 1'b0;
    audio_led_out <= 1'b0;
    video_led_out <= 1'b0;
    commit_led_out <= 1'b0;
    input_led_out <= 4'h0;
    output_led_out <= 2'b00;
  end else begin
    if (refuse_ff != 3'h0) begin
      local_led_out <= fast_phase;
    end else begin
      local_led_out <= local_ff & slow_phase;
    end
    system_mode_indicator_out <= ~local_ff;
    split_led_out <= split_ff;
    audio_led_out <= split_ff & ~video_sel_ff;
    video_led_out <= ~split_ff | video_sel_ff;
    commit_led_out <= local_ff & pend_diff & fast_phase;
    input_led_out[0] <= local_ff && src_ff == 3'h1;
    input_led_out[1] <= local_ff && src_ff == 3'h2;
    input_led_out[2] <= local_ff && src_ff == 3'h3;
    input_led_out[3] <= local_ff && src_ff == 3'h4;
    output_led_out[0] <= local_ff && src_ff != 3'h0 &&
      route_at(edit_video ? pend_v_ff : pend_a_ff, 1'b0) == src_ff;
    output_led_out[1] <= local_ff && src_ff != 3'h0 &&
      route_at(edit_video ? pend_v_ff : pend_a_ff, 1'b1) == src_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
// serial line framing
always @(posedge core_clk_in or negedge rst_n) begin
  if (!rst_n) begin
    line_bad_ff <= 1'b0;
    line_err_ff <= 1'b0;
    line_cnt_ff <= 8'h00;
    line_ok_out <= 1'b0;
    line_bad_out <= 1'b0;
  end else begin
    line_ok_out <= 1'b0;
    line_bad_out <= 1'b0;
    if (apb_write && paddr_in == `OFS_STATUS && pwdata_in[`ST_LINE_ERR_BIT]) begin
      line_err_ff <= 1'b0;
    end
    if (rx_valid_in) begin
      if (rx_data_in == `CHAR_CR) begin
        line_bad_ff <= 1'b0;
        line_ok_out <= ~line_bad_ff;
        line_bad_out <= line_bad_ff;
        line_cnt_ff <= line_cnt_ff + 8'h01;
        if (line_bad_ff) begin
          line_err_ff <= 1'b1;
        end
      end else if (!printable(rx_data_in)) begin
        line_bad_ff <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave, no wait states
always @(posedge core_clk_in or negedge rst_n) begin
  if (!rst_n) begin
    pready_out <= 1'b0;
    pslverr_out <= 1'b0;
    prdata_out <= 32'h0;
  end else begin
    pready_out <= apb_setup;
    pslverr_out <= 1'b0;
    if (apb_setup) begin
      prdata_out <= 32'h0;
      case (paddr_in)
        `OFS_CTRL: begin
          prdata_out[`CTRL_LOCK_BIT] <= lock_ff;
        end
        `OFS_ROUTE: begin
          prdata_out[5:0] <= audio_route_out;
          prdata_out[13:8] <= video_route_out;
        end
        `OFS_STATUS: begin
          prdata_out[`ST_LOCAL_BIT] <= local_ff;
          prdata_out[`ST_SPLIT_BIT] <= split_ff;
          prdata_out[`ST_DIFF_BIT] <= pend_diff;
          prdata_out[`ST_LINE_ERR_BIT] <= line_err_ff;
          prdata_out[`ST_VIDEO_BIT] <= edit_video;
          prdata_out[10:8] <= src_ff;
        end
        `OFS_PENDING: begin
          prdata_out[5:0] <= pend_a_ff;
          prdata_out[13:8] <= pend_v_ff;
        end
        `OFS_SERIAL: begin
          prdata_out[7:0] <= line_cnt_ff;
        end
        default: begin
          pslverr_out <= 1'b1;
        end
      endcase
    end
  end
end

endmodule

// ===== sim/route_editor_monitor.sv
// assertion checker for the front-panel route editor
`timescale 1ns/100ps
module route_editor_monitor (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic commit_btn_in,
  input wire logic system_btn_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic system_mode_indicator_out,
  input wire logic split_led_out,
  input wire logic audio_led_out,
  input wire logic video_led_out,
  input wire logic commit_led_out,
  input wire logic [3:0] input_led_out,
  input wire logic [5:0] audio_route_out,
  input wire logic [5:0] video_route_out,
  input wire logic line_ok_out,
  input wire logic line_bad_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_ready; psel_in && !penable_in |=> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_audio; audio_led_out |-> split_led_out; endproperty
  a_audio: assert property (p_audio) else $error("audio lamp without split");
  property p_split_off; $fell(split_led_out) |-> video_led_out && !audio_led_out; endproperty
  a_split_off: assert property (p_split_off) else $error("lamps wrong at split off");
  property p_sel; (|input_led_out) |-> !system_mode_indicator_out; endproperty
  a_sel: assert property (p_sel) else $error("source lamp outside local");
  property p_flash; commit_led_out |-> !system_mode_indicator_out; endproperty
  a_flash: assert property (p_flash) else $error("commit lamp outside local");
  property p_commit;
    commit_btn_in && !system_mode_indicator_out |-> ##[2:4] !commit_led_out;
  endproperty
  a_commit: assert property (p_commit) else $error("commit lamp stays on");
  property p_hold;
    !$stable({audio_route_out, video_route_out}) |->
      $past(commit_btn_in) || $past(commit_btn_in, 2) || $past(commit_btn_in, 3) ||
      $past(psel_in && penable_in && pwrite_in) ||
      $past(psel_in && penable_in && pwrite_in, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("routes moved without commit");
  property p_sys; system_btn_in |-> ##[1:3] system_mode_indicator_out; endproperty
  a_sys: assert property (p_sys) else $error("system lamp not lit");
  property p_cr;
    line_ok_out || line_bad_out |-> $past(rx_valid_in) && $past(rx_data_in) == 8'h0d;
  endproperty
  a_cr: assert property (p_cr) else $error("line end without return");
  property p_one; !(line_ok_out && line_bad_out); endproperty
  a_one: assert property (p_one) else $error("line good and bad");
endmodule

bind front_panel_route_editor route_editor_monitor u_mon (
  .core_clk_in(core_clk_in),
  .rstn_in(rstn_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .commit_btn_in(commit_btn_in),
  .system_btn_in(system_btn_in),
  .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in),
  .system_mode_indicator_out(system_mode_indicator_out),
  .split_led_out(split_led_out),
  .audio_led_out(audio_led_out),
  .video_led_out(video_led_out),
  .commit_led_out(commit_led_out),
  .input_led_out(input_led_out),
  .audio_route_out(audio_route_out),
  .video_route_out(video_route_out),
  .line_ok_out(line_ok_out),
  .line_bad_out(line_bad_out)
);

// ===== sim/operator_model.sv
// panel operator and serial host model
`timescale 1ns/100ps
module operator_model (
  // clock
  input wire logic clk_in,
  // buttons and serial bytes
  output logic [11:0] btn_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  initial begin
    btn_out = 12'h000;
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
  end
  // one-cycle press then a pause
  task press(input logic [11:0] m);
    btn_out <= m;
    @(posedge clk_in);
    btn_out <= 12'h000;
    repeat (4) @(posedge clk_in);
  endtask
  task send(input logic [7:0] ch);
    rx_data_out <= ch;
    rx_valid_out <= 1'b1;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~ch;
    @(posedge clk_in);
  endtask
endmodule

// ===== sim/front_panel_route_editor_tb.sv
// self-checking bench for the front-panel route editor
`timescale 1ns/100ps
`include "route_defs.vh"
module front_panel_route_editor_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, rx_data;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sys_led, loc_led, split_led, aud_led, vid_led, com_led, ok, bad, rx_valid;
  logic [3:0] in_led;
  logic [1:0] out_led;
  logic [5:0] a_rt, v_rt;
  logic [11:0] btn;
  logic [33:0] e;
  logic [33:0] apb_q[$];
  logic ser_q[$];
  int err_total = 0, n_compared = 0, cyc = 0, n;
  int seed = 32'hfce1c706;
  always #4 clk = ~clk;
  front_panel_route_editor #(.SLOW_HALF_CYC(32'd8), .FAST_HALF_CYC(32'd2)) u_dut (
    .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .input_btn_in(btn[3:0]),
    .output_btn_in(btn[5:4]), .split_btn_in(btn[6]), .audio_btn_in(btn[7]),
    .video_btn_in(btn[8]), .commit_btn_in(btn[9]), .local_btn_in(btn[10]),
    .system_btn_in(btn[11]), .local_led_out(loc_led), .system_mode_indicator_out(sys_led),
    .split_led_out(split_led), .audio_led_out(aud_led), .video_led_out(vid_led),
    .commit_led_out(com_led), .input_led_out(in_led), .output_led_out(out_led),
    .audio_route_out(a_rt), .video_route_out(v_rt), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .line_ok_out(ok), .line_bad_out(bad));
  operator_model u_op (.clk_in(clk), .btn_out(btn), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task chk_rt(input logic [5:0] a, input logic [5:0] v);
    chk(a_rt, a);
    chk(v_rt, v);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er,
           input logic [31:0] x);
    apb_q.push_back({er, ~wr, x});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (pready === 1'b1 && apb_q.size() > 0) begin
      e = apb_q.pop_front();
      chk(pslverr, e[33]);
      if (e[32]) chk(prdata, e[31:0]);
    end
    if ((ok | bad) === 1'b1 && ser_q.size() > 0) chk(ok, ser_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      err_total++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(sys_led, 1'b1);
    chk(vid_led, 1'b1);
    apb(0, `OFS_CTRL, 0, 0, 0);
    apb(0, `OFS_ROUTE, 0, 0, 0);
    apb(0, 8'h14, 0, 1, 0);
    apb(1, `OFS_ROUTE, 32'h1111, 0, 0);
    apb(0, `OFS_ROUTE, 0, 0, 32'h1111);
    chk_rt(6'h11, 6'h11);
    $display("register test done");
    u_op.press(12'h400);
    chk(sys_led, 1'b0);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (loc_led === 1'b1) n++;
    end
    chk(n > 10 && n < 30, 1'b1);
    u_op.press(12'h002);
    chk(in_led, 4'h2);
    chk(out_led, 2'b10);
    u_op.press(12'h010);
    chk(out_led, 2'b11);
    u_op.press(12'h020);
    chk(out_led, 2'b01);
    chk_rt(6'h11, 6'h11);
    n = 0;
    while (com_led !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(com_led, 1'b1);
    u_op.press(12'h200);
    chk_rt(6'h02, 6'h02);
    chk(com_led, 1'b0);
    apb(1, `OFS_ROUTE, 32'h0909, 0, 0);
    apb(0, `OFS_ROUTE, 0, 0, 32'h0202);
    $display("joint edit test done");
    u_op.press(12'h040);
    chk({split_led, aud_led, vid_led}, 3'b110);
    u_op.press(12'h008);
    u_op.press(12'h020);
    chk(out_led, 2'b10);
    u_op.press(12'h100);
    chk(vid_led, 1'b1);
    u_op.press(12'h010);
    chk(out_led, 2'b01);
    chk_rt(6'h02, 6'h02);
    u_op.press(12'h200);
    chk_rt(6'h22, 6'h04);
    u_op.press(12'h040);
    chk({split_led, vid_led}, 2'b01);
    u_op.press(12'h200);
    chk_rt(6'h04, 6'h04);
    $display("split edit test done");
    ser_q.push_back(1'b1);
    repeat (3) u_op.send(8'h20 + 8'({$random(seed)} % 95));
    u_op.send(`CHAR_CR);
    ser_q.push_back(1'b0);
    u_op.send(8'h07);
    u_op.send(`CHAR_CR);
    repeat (3) @(posedge clk);
    chk(ser_q.size(), 0);
    $display("serial test done");
    apb(0, `OFS_STATUS, 0, 0, 32'h0419);
    apb(0, `OFS_SERIAL, 0, 0, 32'h0002);
    apb(1, `OFS_STATUS, 32'h8, 0, 0);
    apb(0, `OFS_STATUS, 0, 0, 32'h0411);
    apb(0, `OFS_PENDING, 0, 0, 32'h0404);
    u_op.press(12'h080);
    chk({aud_led, vid_led}, 2'b01);
    u_op.press(12'h800);
    chk(sys_led, 1'b1);
    u_op.press(12'h400);
    chk(sys_led, 1'b0);
    chk(in_led, 4'h0);
    $display("mode test done");
    apb(1, `OFS_CTRL, 32'h1, 0, 0);
    apb(0, `OFS_CTRL, 0, 0, 32'h1);
    repeat (3) @(posedge clk);
    chk(sys_led, 1'b1);
    u_op.press(12'h400);
    chk(sys_led, 1'b1);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (loc_led === 1'b1) n++;
    end
    chk(n > 0 && n < 8, 1'b1);
    chk(loc_led, 1'b0);
    u_op.press(12'h001);
    chk(in_led, 4'h0);
    $display("lock test done");
    repeat (5) @(posedge clk);
    end_of_test();
  end
endmodule
